// ==== rtl/mvu_pkg.sv ====
// package: register map, field layout and codes of the engine control bank
// Behaviour
// - engine enable bit 0 gates engine operation
// - idle clock kept only when bit 1 set
// - writing 1 starts channel; 0 ignored
// - start bits self clear; always read zero
// - start picks work from schedule and task
// - two 4-bit task fields, read/write
// - task codes 0..8 defined, 9..f reserved
// - task field selects work on software start
// - schedule codes 0,1,4,9; others reserved
// - repeat count 0 skips; 1-15 runs n
// - forced termination bit aborts running schedule
`default_nettype none
package mvu_pkg;
   // -----------------------------------------------------------------
   // register byte addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_ENABLE    = 8'h00;
   localparam logic [7:0] ADDR_START     = 8'h04;
   localparam logic [7:0] ADDR_TASK      = 8'h08;
   localparam logic [7:0] ADDR_SCHED     = 8'h0c;
   localparam logic [7:0] ADDR_REPEAT    = 8'h10;
   localparam logic [7:0] ADDR_TERMINATE = 8'h14;
   localparam logic [7:0] ADDR_STATUS    = 8'h18;
   // -----------------------------------------------------------------
   // field positions and widths
   // -----------------------------------------------------------------
   localparam int BIT_ENABLE     = 0;
   localparam int BIT_IDLE_KEEP  = 1;
   localparam int NUM_CH         = 2;
   localparam int FIELD_W        = 4;
   localparam int STATUS_REM_POS = 4;
   localparam logic [1:0] CTRL_RESET  = 2'h0;
   localparam logic [7:0] FIELD_RESET = 8'h00;
   // -----------------------------------------------------------------
   // codes
   // -----------------------------------------------------------------
   localparam logic [3:0] TASK_LAST   = 4'h8;
   localparam logic [3:0] SCHED_SINGLE = 4'h0;
   localparam logic [3:0] SCHED_ONE   = 4'h1;
   localparam logic [3:0] SCHED_FOUR  = 4'h4;
   localparam logic [3:0] SCHED_NINE  = 4'h9;
   localparam logic [3:0] REPEAT_NONE = 4'h0;
   localparam logic [3:0] ONE4        = 4'h1;
   // cycles one schedule pass lasts in this model of the sequencer
   localparam logic [3:0] PASS_CYCLES = 4'h8;
endpackage : mvu_pkg
`default_nettype wire

// ==== rtl/mvu_chan_seq.sv ====
// module: per-channel run sequencer deciding and counting the work
`default_nettype none
module mvu_chan_seq (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       enable,
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic [3:0] task_code,
   input  wire logic [3:0] sched_code,
   input  wire logic [3:0] repeat_count,
   output logic            busy,
   output logic [3:0]      run_task,
   output logic [3:0]      run_sched,
   output logic [3:0]      passes_left
);
   typedef enum logic [1:0] {ST_IDLE, ST_RUN} mvu_st_t;
   typedef struct packed {
      mvu_st_t    st;
      logic [3:0] task_c;
      logic [3:0] sched;
      logic [3:0] left;
      logic [3:0] tick;
   } mvu_seq_t;
   mvu_seq_t s_q;
   mvu_seq_t s_d;
   logic sched_ok;
   logic task_ok;

   // -----------------------------------------------------------------
   // run control
   // -----------------------------------------------------------------
   always_comb begin
      sched_ok = (sched_code == mvu_pkg::SCHED_ONE) ||
                 (sched_code == mvu_pkg::SCHED_FOUR) ||
                 (sched_code == mvu_pkg::SCHED_NINE);
      task_ok = (task_code <= mvu_pkg::TASK_LAST);
      s_d = s_q;
      case (s_q.st)
         ST_IDLE: begin
            if (start && enable) begin
               s_d.sched  = sched_code;
               s_d.task_c = task_code;
               s_d.tick   = mvu_pkg::PASS_CYCLES;
               if (sched_code == mvu_pkg::SCHED_SINGLE && task_ok) begin
                  s_d.left = mvu_pkg::ONE4;
                  s_d.st   = ST_RUN;
               end else if (sched_ok &&
                            repeat_count != mvu_pkg::REPEAT_NONE) begin
                  s_d.left = repeat_count;
                  s_d.st   = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            if (abort || !enable) begin
               s_d.st   = ST_IDLE;
               s_d.left = 4'h0;
            end else if (s_q.tick == mvu_pkg::ONE4) begin
               s_d.tick = mvu_pkg::PASS_CYCLES;
               s_d.left = s_q.left - mvu_pkg::ONE4;
               if (s_q.left == mvu_pkg::ONE4) begin
                  s_d.st = ST_IDLE;
               end
            end else begin
               s_d.tick = s_q.tick - mvu_pkg::ONE4;
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   always_comb begin
      busy        = (s_q.st == ST_RUN);
      run_task    = s_q.task_c;
      run_sched   = s_q.sched;
      passes_left = s_q.left;
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_abort_stops: assert property (@(posedge clock) disable iff (rst)
      (busy && abort) |=> !busy)
      else $error("abort did not stop channel");
   a_zero_repeat: assert property (@(posedge clock) disable iff (rst)
      (!busy && start && sched_code != mvu_pkg::SCHED_SINGLE &&
       repeat_count == mvu_pkg::REPEAT_NONE) |=> !busy)
      else $error("zero repeat ran schedule");
   a_disabled_idle: assert property (@(posedge clock) disable iff (rst)
      (!enable) |=> !busy)
      else $error("ran while disabled");
   a_single_once: assert property (@(posedge clock) disable iff (rst)
      (!busy && start && enable && sched_code == mvu_pkg::SCHED_SINGLE &&
       task_code <= mvu_pkg::TASK_LAST) |=> busy ##8 !busy)
      else $error("single task length wrong");
   c_sched_run: cover property (@(posedge clock) disable iff (rst)
      (start && sched_code == mvu_pkg::SCHED_FOUR) ##1 busy);
   c_abort: cover property (@(posedge clock) disable iff (rst)
      busy && abort);
endmodule : mvu_chan_seq
`default_nettype wire

// ==== rtl/mvu_ctrl.sv ====
// module: control register bank on AHB-Lite with two channel sequencers
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`default_nettype none
module mvu_ctrl (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             engine_enable,
   output logic             engine_clk_en,
   input  wire logic        cpu_idle,
   output logic [1:0]       ch_busy
);
   typedef struct packed {
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic        ctrl_en;
      logic        idle_keep;
      logic [7:0]  task_sel;
      logic [7:0]  sched_sel;
      logic [7:0]  rep_cnt;
      logic [1:0]  start_p;
      logic [1:0]  term_p;
      logic [31:0] rdata;
      logic        clk_en;
      logic        en_o;
      logic [1:0]  busy_o;
   } mvu_ctrl_t;
   mvu_ctrl_t r_q;
   mvu_ctrl_t r_d;
   logic       idle_s1_q;
   logic       idle_s2_q;
   logic [1:0] busy_w;
   logic [7:0] rem_w [2];
   logic       addr_ok;
   logic [7:0] a8;

   // -----------------------------------------------------------------
   // idle input synchroniser
   // -----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         idle_s1_q <= 1'b0;
         idle_s2_q <= 1'b0;
      end else begin
         idle_s1_q <= cpu_idle;
         idle_s2_q <= idle_s1_q;
      end
   end

   // -----------------------------------------------------------------
   // bus and register logic
   // -----------------------------------------------------------------
   always_comb begin
      a8 = haddr[7:0];
      addr_ok = (haddr[31:8] == 24'h000000) && (a8[1:0] == 2'h0) &&
                (a8 <= mvu_pkg::ADDR_STATUS);
      r_d = r_q;
      r_d.start_p = 2'h0;
      r_d.term_p  = 2'h0;
      r_d.wr_pend = 1'b0;
      // data phase of a write
      if (r_q.wr_pend) begin
         case (r_q.wr_addr)
            mvu_pkg::ADDR_ENABLE: begin
               r_d.ctrl_en   = hwdata[mvu_pkg::BIT_ENABLE];
               r_d.idle_keep = hwdata[mvu_pkg::BIT_IDLE_KEEP];
            end
            mvu_pkg::ADDR_START: begin
               r_d.start_p = hwdata[1:0];
            end
            mvu_pkg::ADDR_TASK: begin
               r_d.task_sel = hwdata[7:0];
            end
            mvu_pkg::ADDR_SCHED: begin
               r_d.sched_sel = hwdata[7:0];
            end
            mvu_pkg::ADDR_REPEAT: begin
               r_d.rep_cnt = hwdata[7:0];
            end
            mvu_pkg::ADDR_TERMINATE: begin
               r_d.term_p = hwdata[1:0];
            end
            default: begin
               r_d.rdata = r_q.rdata;
            end
         endcase
      end
      // address phase
      if (hsel && hready && htrans[1]) begin
         r_d.wr_pend = hwrite && addr_ok;
         r_d.wr_addr = a8;
         r_d.rdata   = 32'h00000000;
         if (!hwrite && addr_ok) begin
            case (a8)
               mvu_pkg::ADDR_ENABLE:
                  r_d.rdata[1:0] = {r_q.idle_keep, r_q.ctrl_en};
               mvu_pkg::ADDR_TASK:   r_d.rdata[7:0] = r_q.task_sel;
               mvu_pkg::ADDR_SCHED:  r_d.rdata[7:0] = r_q.sched_sel;
               mvu_pkg::ADDR_REPEAT: r_d.rdata[7:0] = r_q.rep_cnt;
               mvu_pkg::ADDR_STATUS: begin
                  r_d.rdata[1:0] = busy_w;
                  // ch0 passes in the low nibble, ch1 in the high one
                  r_d.rdata[mvu_pkg::STATUS_REM_POS +: 8] =
                     {rem_w[1][3:0], rem_w[0][3:0]};
               end
               default: r_d.rdata = 32'h00000000;
            endcase
         end
      end
      // outputs
      r_d.en_o   = r_d.ctrl_en;
      r_d.clk_en = r_d.ctrl_en && (!idle_s2_q || r_d.idle_keep);
      r_d.busy_o = busy_w;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // -----------------------------------------------------------------
   // channel sequencers
   // -----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < mvu_pkg::NUM_CH; g = g + 1) begin : g_ch
         logic [3:0] rem_t;
         mvu_chan_seq u_seq (
            .clock        (clock),
            .rst          (rst),
            .enable       (r_q.ctrl_en),
            .start        (r_q.start_p[g]),
            .abort        (r_q.term_p[g]),
            .task_code    (r_q.task_sel[g*4 +: 4]),
            .sched_code   (r_q.sched_sel[g*4 +: 4]),
            .repeat_count (r_q.rep_cnt[g*4 +: 4]),
            .busy         (busy_w[g]),
            .run_task     (),
            .run_sched    (),
            .passes_left  (rem_t)
         );
         assign rem_w[g] = {4'h0, rem_t};
      end
   endgenerate

   always_comb begin
      hrdata        = r_q.rdata;
      hreadyout     = 1'b1;
      hresp         = 1'b0;
      engine_enable = r_q.en_o;
      engine_clk_en = r_q.clk_en;
      ch_busy       = r_q.busy_o;
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_start_pulse: assert property (@(posedge clock) disable iff (rst)
      (r_q.start_p != 2'h0) |=> (r_q.start_p == 2'h0))
      else $error("start bit did not self clear");
   a_start_read: assert property (@(posedge clock) disable iff (rst)
      (hsel && hready && htrans[1] && !hwrite &&
       haddr == 32'h00000004) |=> (hrdata == 32'h00000000))
      else $error("start register read nonzero");
   a_idle_gate: assert property (@(posedge clock) disable iff (rst)
      (idle_s2_q && !r_q.idle_keep && !r_d.idle_keep) |=>
      !engine_clk_en)
      else $error("clock kept in idle");
   a_enable_out: assert property (@(posedge clock) disable iff (rst)
      (r_q.wr_pend && r_q.wr_addr == mvu_pkg::ADDR_ENABLE) |=>
      (engine_enable == $past(hwdata[mvu_pkg::BIT_ENABLE])))
      else $error("enable output mismatch");
   a_start_effect: assert property (@(posedge clock) disable iff (rst)
      (r_q.wr_pend && r_q.wr_addr == mvu_pkg::ADDR_START &&
       hwdata[0]) |=> r_q.start_p[0])
      else $error("start write lost");
   a_task_store: assert property (@(posedge clock) disable iff (rst)
      (r_q.wr_pend && r_q.wr_addr == mvu_pkg::ADDR_TASK) |=>
      (r_q.task_sel == $past(hwdata[7:0])))
      else $error("task field not stored");
   c_write_start: cover property (@(posedge clock) disable iff (rst)
      r_q.start_p[1]);
   c_idle_keep: cover property (@(posedge clock) disable iff (rst)
      idle_s2_q && engine_clk_en);
endmodule : mvu_ctrl
`default_nettype wire

// ==== test/tb.sv ====
// testbench: register bank and channel start checks of the engine control
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
      miscompares++; $display("BAD %0t mismatch", $time); end end
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        engine_enable;
   logic        engine_clk_en;
   logic        cpu_idle = 1'b0;
   logic [1:0]  ch_busy;
   logic [31:0] lfsr_q = 32'h1613;
   logic [31:0] rd;
   logic [31:0] v;
   int          miscompares = 0;
   int          n_tests = 0;
   mvu_ctrl dut_u (
      .clock         (clock),
      .rst           (rst),
      .hsel          (hsel),
      .haddr         (haddr),
      .htrans        (htrans),
      .hwrite        (hwrite),
      .hsize         (hsize),
      .hwdata        (hwdata),
      .hready        (hreadyout),
      .hrdata        (hrdata),
      .hreadyout     (hreadyout),
      .hresp         (hresp),
      .engine_enable (engine_enable),
      .engine_clk_en (engine_clk_en),
      .cpu_idle      (cpu_idle),
      .ch_busy       (ch_busy)
   );
   initial begin
      forever #10 clock = ~clock;
   end
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
   endfunction : lfsr
   task automatic ahb(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
      `CHK(hresp, 1'b0)
   endtask : ahb
   // model: busy cycles a start should produce
   function automatic int model(input int tk, input int sc, input int rp);
      if (sc == 0) model = (tk <= 8) ? 8 : 0;
      else if (sc == 1 || sc == 4 || sc == 9) model = 8 * rp;
      else model = 0;
   endfunction : model
   // window covers the longest run of fifteen passes plus latency
   task automatic run(input int ch, input int tk, input int sc, input int rp,
                      input logic en, input logic go);
      int c[2];
      int e;
      c = '{0, 0};
      e = (en && go) ? model(tk, sc, rp) : 0;
      ahb(1'b1, 32'h00, {31'h0, en}, rd);
      ahb(1'b1, 32'h08, {24'h0, tk[3:0], tk[3:0]}, rd);
      ahb(1'b1, 32'h0c, {24'h0, sc[3:0], sc[3:0]}, rd);
      ahb(1'b1, 32'h10, {24'h0, rp[3:0], rp[3:0]}, rd);
      ahb(1'b1, 32'h04, {30'h0, go, 1'b0} >> (1 - ch), rd);
      repeat (140) begin
         @(posedge clock);
         if (ch_busy[0] === 1'b1) c[0]++;
         if (ch_busy[1] === 1'b1) c[1]++;
      end
      `CHK(c[ch], e)
      `CHK(c[1 - ch], 0)
   endtask : run
   task automatic complete_run();
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   initial begin
      #600000;
      miscompares++;
      complete_run();
   end
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      int t0;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      for (int a = 0; a < 32'h20; a += 4) begin
         ahb(1'b0, a, 32'h0, rd);
         `CHK(rd, 32'h0)
      end
      ahb(1'b1, 32'h200, 32'hffffffff, rd);
      ahb(1'b0, 32'h200, 32'h0, rd);
      `CHK(rd, 32'h0)
      // the unmapped write must not alias onto the enable register
      ahb(1'b0, 32'h00, 32'h0, rd);
      `CHK(rd, 32'h0)
      for (int i = 0; i < 8; i++) begin
         lfsr_q = lfsr(lfsr_q);
         v = lfsr_q;
         ahb(1'b1, 32'h08 + 4 * (i % 3), v, rd);
         ahb(1'b0, 32'h08 + 4 * (i % 3), 32'h0, rd);
         `CHK(rd, v & 32'hff)
         ahb(1'b1, 32'h04, v & 32'hfffffffc, rd);
         ahb(1'b0, 32'h04, 32'h0, rd);
         `CHK(rd, 32'h0)
         ahb(1'b1, 32'h00, v, rd);
         ahb(1'b0, 32'h00, 32'h0, rd);
         `CHK(rd, v & 32'h3)
         repeat (2) @(posedge clock);
         `CHK(engine_enable, v[0])
      end
      // idle clock gating, cpu_idle goes through a synchroniser first
      for (int i = 0; i < 8; i++) begin
         cpu_idle <= i[0];
         ahb(1'b1, 32'h00, {30'h0, i[1], ~i[2]}, rd);
         repeat (5) @(posedge clock);
         `CHK(engine_clk_en, ~i[2] & (~i[0] | i[1]))
      end
      cpu_idle <= 1'b0;
      for (int tk = 0; tk < 16; tk++) run(tk % 2, tk, 0, 0, 1'b1, 1'b1);
      for (int sc = 0; sc < 16; sc++) begin
         lfsr_q = lfsr(lfsr_q);
         run(sc % 2, 3, sc, lfsr_q[1:0], 1'b1, 1'b1);
      end
      run(0, 2, 1, 15, 1'b1, 1'b1);
      run(1, 2, 0, 0, 1'b0, 1'b1);
      run(0, 2, 0, 0, 1'b1, 1'b0);
      // abort mid schedule: busy must drop soon after the terminate write
      // a long schedule, so the channel is still running at the abort
      ahb(1'b1, 32'h0c, 32'h11, rd);
      ahb(1'b1, 32'h10, 32'hff, rd);
      ahb(1'b1, 32'h04, 32'h2, rd);
      repeat (20) @(posedge clock);
      `CHK(ch_busy[1], 1'b1)
      // 13 passes left early in the third pass of eight cycles
      ahb(1'b0, 32'h18, 32'h0, rd);
      `CHK(rd, 32'h00000d02)
      ahb(1'b1, 32'h14, 32'h2, rd);
      t0 = 0;
      while (ch_busy[1] === 1'b1 && t0 < 6) begin
         @(posedge clock);
         t0++;
      end
      `CHK(ch_busy[1], 1'b0)
      ahb(1'b0, 32'h14, 32'h0, rd);
      `CHK(rd, 32'h0)
      // restart only after the terminate, then drop the enable mid run
      ahb(1'b1, 32'h04, 32'h2, rd);
      repeat (3) @(posedge clock);
      `CHK(ch_busy[1], 1'b1)
      ahb(1'b1, 32'h00, 32'h0, rd);
      repeat (3) @(posedge clock);
      `CHK(ch_busy[1], 1'b0)
      `CHK(engine_enable, 1'b0)
      complete_run();
   end
endmodule : tb
`default_nettype wire
